// *** hw/ctu_ctrl.sv ***
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "ctu_defs.svh"
module ctu_ctrl (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] comparator_out_i,
	input wire logic [2:0] capture_event_i,
	input wire logic compare_channel_one_event_i,
	input wire logic timer_one_event_i,
	input wire logic [7:0] edge_input_pin_i,
	output logic adc_cap_discharge_o,
	output logic edge_one_occurred_o,
	output logic edge_two_occurred_o,
	output logic irq_o
);
	logic [31:0] ctrl_ff;
	logic [1:0] stat_ff;
	logic [1:0] ien_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic dis_ff;
	logic irq_ff;
	logic [15:0] raw_src;
	logic [15:0] pin_sync;
	logic [15:0] src_vec;
	logic e1_hit;
	logic e2_hit;
	logic wr_acc;
	logic rd_acc;
	logic [1:0] nxt_stat;
	logic [1:0] nxt_ien;
	logic [1:0] warm_ff;
	ctu_edge_if e1_if();
	ctu_edge_if e2_if();

	// pins and comparators are asynchronous; event inputs are on-clock
	assign raw_src = {comparator_out_i, 3'h0, edge_input_pin_i, 2'h0};
	ctu_sync u_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(raw_src),
		.q_o(pin_sync)
	);
	always_comb begin
		src_vec = pin_sync;
		src_vec[12:10] = capture_event_i;
		src_vec[3] = edge_input_pin_sync(pin_sync, 0);
		src_vec[2] = edge_input_pin_sync(pin_sync, 1);
		src_vec[1] = compare_channel_one_event_i;
		src_vec[0] = timer_one_event_i;
	end

	// code 0011 is pin 1 and 0010 pin 2, so pins 1 and 2 swap positions
	function automatic logic edge_input_pin_sync(input logic [15:0] v, input int idx);
		edge_input_pin_sync = (idx == 0) ? v[2] : v[3];
	endfunction : edge_input_pin_sync

	function automatic ctu_pkg::ctu_edge_cfg_t cfg_of(input logic [31:0] r, input logic two);
		ctu_pkg::ctu_edge_cfg_t c;
		if (two) begin
			c = {r[`CTU_E2MOD_BIT], r[`CTU_E2POL_BIT], r[`CTU_E2SEL_HI:`CTU_E2SEL_LO]};
		end else begin
			c = {r[`CTU_E1MOD_BIT], r[`CTU_E1POL_BIT], r[`CTU_E1SEL_HI:`CTU_E1SEL_LO]};
		end
		cfg_of = c;
	endfunction : cfg_of

	assign e1_if.cfg = cfg_of(ctrl_ff, 1'b0);
	assign e1_if.src = src_vec;
	assign e2_if.cfg = cfg_of(ctrl_ff, 1'b1);
	assign e2_if.src = src_vec;
	ctu_edge_det u_e1 (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.eif(e1_if)
	);
	ctu_edge_det u_e2 (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.eif(e2_if)
	);
	assign e1_hit = e1_if.hit & ctrl_ff[`CTU_ON_BIT] & ctrl_ff[`CTU_EDGEN_BIT];
	assign e2_hit = e2_if.hit & ctrl_ff[`CTU_ON_BIT] & ctrl_ff[`CTU_EDGEN_BIT];

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;

	// control word; hardware set of status bits wins over a software write
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_ff <= `CTU_CTRL_RST;
		end else begin
			if (wr_acc && paddr == `CTU_CTRL_OFF) begin
				ctrl_ff <= pwdata & `CTU_CTRL_MASK;
			end
			if (e2_hit) begin
				ctrl_ff[`CTU_E2STAT_BIT] <= 1'b1;
			end
			if (e1_hit) begin
				ctrl_ff[`CTU_E1STAT_BIT] <= 1'b1;
			end
		end
	end

	// sticky interrupt status, set beats clear
	always_comb begin
		nxt_stat = stat_ff;
		if (wr_acc && paddr == `CTU_CLR_OFF) begin
			nxt_stat = stat_ff & ~pwdata[`CTU_NUM_EVT-1:0];
		end
		nxt_stat = nxt_stat | {e2_hit, e1_hit};
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stat_ff <= 2'h0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end
	always_comb begin
		nxt_ien = ien_ff;
		if (wr_acc && paddr == `CTU_IEN_OFF) begin
			nxt_ien = pwdata[`CTU_NUM_EVT-1:0];
		end
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ien_ff <= 2'h0;
		end else begin
			ien_ff <= nxt_ien;
		end
	end
	// next-state mask too, so enabling or masking takes effect with the write
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_stat & nxt_ien);
		end
	end

	// sync pipe still holds reset zeros for two edges after release
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			warm_ff <= 2'h0;
		end else if (warm_ff != 2'h3) begin
			warm_ff <= warm_ff + 2'h1;
		end
	end

	// discharge only by software request; no hidden per-conversion discharge
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dis_ff <= 1'b0;
		end else begin
			dis_ff <= ctrl_ff[`CTU_DIS_BIT];
		end
	end

	// no wait state: read data is prepared in setup, pready in access
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel & ~penable;
			pslverr_ff <= 1'b0;
			if (psel & ~penable) begin
				if (!(paddr == `CTU_CTRL_OFF || paddr == `CTU_STAT_OFF ||
					paddr == `CTU_CLR_OFF || paddr == `CTU_IEN_OFF)) begin
					pslverr_ff <= 1'b1;
				end
			end
			if (rd_acc) begin
				if (paddr == `CTU_CTRL_OFF) begin
					prdata_ff <= ctrl_ff;
				end else if (paddr == `CTU_STAT_OFF) begin
					prdata_ff <= {30'h0, stat_ff};
				end else if (paddr == `CTU_IEN_OFF) begin
					prdata_ff <= {30'h0, ien_ff};
				end else begin
					prdata_ff <= 32'h00000000;
				end
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign adc_cap_discharge_o = dis_ff;
	assign edge_one_occurred_o = ctrl_ff[`CTU_E1STAT_BIT];
	assign edge_two_occurred_o = ctrl_ff[`CTU_E2STAT_BIT];
	assign irq_o = irq_ff;

	property p_e2_set;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		e2_hit |=> ctrl_ff[`CTU_E2STAT_BIT];
	endproperty
	e2_status_set_a: assert property (p_e2_set) else $error("edge two flag not set");
	e1_status_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		e1_hit |=> ctrl_ff[`CTU_E1STAT_BIT] && stat_ff[0]) else $error("edge one not recorded");
	discharge_follow_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		adc_cap_discharge_o == $past(ctrl_ff[`CTU_DIS_BIT])) else $error("discharge mismatch");
	no_auto_dis_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!ctrl_ff[`CTU_DIS_BIT] ##1 !ctrl_ff[`CTU_DIS_BIT] |-> !adc_cap_discharge_o)
		else $error("unrequested discharge");
	edge_pos_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		e1_if.cfg.mode && e1_if.cfg.pol && e1_if.hit |-> !$past(src_vec[e1_if.cfg.sel]))
		else $error("rising edge without low before");
	level_hit_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!e1_if.cfg.mode |-> e1_if.hit == (src_vec[e1_if.cfg.sel] == e1_if.cfg.pol))
		else $error("level sensing wrong");
	sel_c2_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		warm_ff[1] && e2_if.cfg.sel == `CTU_SEL_C2 |->
		e2_if.src[e2_if.cfg.sel] == $past(comparator_out_i[1], 2))
		else $error("comparator two misrouted");
	pin_map_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		warm_ff[1] |-> src_vec[3] == $past(edge_input_pin_i[0], 2) &&
		src_vec[2] == $past(edge_input_pin_i[1], 2) &&
		src_vec[9] == $past(edge_input_pin_i[7], 2) && src_vec[0] == timer_one_event_i)
		else $error("pin map wrong");
	irq_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		|(stat_ff & ien_ff) |-> irq_o) else $error("irq missing");
	irq_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!(|(stat_ff & ien_ff)) |-> !irq_o) else $error("irq without enabled status");
	e2_fall_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		e2_if.cfg.mode && !e2_if.cfg.pol && e2_if.hit |-> $past(e2_if.src[e2_if.cfg.sel]))
		else $error("edge two fall without high before");
	ready_pulse_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		pready |=> !pready) else $error("ready longer than one cycle");
	cover property (@(posedge core_clk_i) e2_hit);
	cover property (@(posedge core_clk_i) e1_hit && e1_if.cfg.mode);
	cover property (@(posedge core_clk_i) adc_cap_discharge_o);
	cover property (@(posedge core_clk_i) irq_o);
endmodule : ctu_ctrl

// *** hw/ctu_defs.svh ***
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH
`define CTU_CTRL_OFF 12'h000
`define CTU_STAT_OFF 12'h004
`define CTU_CLR_OFF 12'h008
`define CTU_IEN_OFF 12'h00C
`define CTU_E1MOD_BIT 31
`define CTU_E1POL_BIT 30
`define CTU_E1SEL_HI 29
`define CTU_E1SEL_LO 26
`define CTU_E2STAT_BIT 25
`define CTU_E1STAT_BIT 24
`define CTU_E2MOD_BIT 23
`define CTU_E2POL_BIT 22
`define CTU_E2SEL_HI 21
`define CTU_E2SEL_LO 18
`define CTU_ON_BIT 15
`define CTU_PULSE_DELAY_ENABLE_BIT 12
`define CTU_EDGEN_BIT 11
`define CTU_DIS_BIT 9
`define CTU_CTRL_MASK 32'hFFFCBFFF
`define CTU_CTRL_RST 32'h00000000
`define CTU_SEL_C2 4'hE
`define CTU_NUM_EVT 2
`endif

// *** hw/ctu_pkg.sv ***
package ctu_pkg;
	typedef enum logic [1:0] {
		CTU_IDLE = 2'b00,
		CTU_ACCESS = 2'b01
	} ctu_bus_st_t;
	typedef struct packed {
		logic mode;
		logic pol;
		logic [3:0] sel;
	} ctu_edge_cfg_t;
endpackage : ctu_pkg

// *** hw/ctu_edge_if.sv ***
`timescale 1ns/10ps
interface ctu_edge_if;
	ctu_pkg::ctu_edge_cfg_t cfg;
	logic [15:0] src;
	logic hit;
	modport ctl(output cfg, output src, input hit);
	modport det(input cfg, input src, output hit);
endinterface : ctu_edge_if

// *** hw/ctu_edge_det.sv ***
`timescale 1ns/10ps
`include "ctu_defs.svh"
module ctu_edge_det (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	ctu_edge_if.det eif
);
	logic cur;
	logic prev_ff;
	always_comb begin
		cur = eif.src[eif.cfg.sel];
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= cur;
		end
	end
	// edge mode fires once per transition; level mode fires every active cycle
	always_comb begin
		if (eif.cfg.mode) begin
			eif.hit = eif.cfg.pol ? (cur & ~prev_ff) : (~cur & prev_ff);
		end else begin
			eif.hit = eif.cfg.pol ? cur : ~cur;
		end
	end
endmodule : ctu_edge_det

// *** hw/ctu_sync.sv ***
`timescale 1ns/10ps
module ctu_sync (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] d_i,
	output logic [15:0] q_o
);
	logic [15:0] s1_ff;
	logic [15:0] s2_ff;
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_ff <= 16'h0000;
			s2_ff <= 16'h0000;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
		end
	end
	assign q_o = s2_ff;
endmodule : ctu_sync

// *** tb/ctu_src_model.sv ***
`timescale 1ns/10ps
module ctu_src_model (
	input wire logic [3:0] sel_i,
	input wire logic lvl_i,
	output logic [2:0] cmp_o,
	output logic [2:0] cap_o,
	output logic oc_o,
	output logic tmr_o,
	output logic [7:0] pin_o
);
	// only the chosen source moves, so a wrong decode sees a dead line
	always_comb begin
		cmp_o = 3'h0;
		cap_o = 3'h0;
		oc_o = 1'b0;
		tmr_o = 1'b0;
		pin_o = 8'h00;
		if (sel_i >= 4'hD) cmp_o[2'(sel_i - 4'hD)] = lvl_i;
		else if (sel_i >= 4'hA) cap_o[2'(sel_i - 4'hA)] = lvl_i;
		else if (sel_i >= 4'h4) pin_o[3'(sel_i - 4'h2)] = lvl_i;
		else if (sel_i == 4'h3) pin_o[0] = lvl_i;
		else if (sel_i == 4'h2) pin_o[1] = lvl_i;
		else if (sel_i == 4'h1) oc_o = lvl_i;
		else tmr_o = lvl_i;
	end
endmodule : ctu_src_model

// *** tb/charge_time_edge_control_tb_top.sv ***
`timescale 1ns/10ps
`include "ctu_defs.svh"
module charge_time_edge_control_tb_top;
	localparam logic [31:0] EN = 32'h00008800;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, dis, f1, f2, irq, s;
	logic [3:0] sel = 4'h0;
	logic lvl = 1'b0;
	logic [2:0] cmp, cap;
	logic oc, tm;
	logic [7:0] pin;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2 core_clk_i = ~core_clk_i;
	ctu_src_model i_ctu_src_model (.sel_i(sel), .lvl_i(lvl), .cmp_o(cmp), .cap_o(cap),
		.oc_o(oc), .tmr_o(tm), .pin_o(pin));
	ctu_ctrl i_ctu_ctrl (.core_clk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .comparator_out_i(cmp), .capture_event_i(cap),
		.compare_channel_one_event_i(oc), .timer_one_event_i(tm), .edge_input_pin_i(pin),
		.adc_cap_discharge_o(dis), .edge_one_occurred_o(f1), .edge_two_occurred_o(f2),
		.irq_o(irq));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// hold the request until pready is sampled high; bench timeout ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_flag(input bit two, output logic seen);
		seen = 1'b0;
		repeat (12) begin
			@(posedge core_clk_i);
			if ((two ? f2 : f1) === 1'b1) seen = 1'b1;
		end
	endtask : wait_flag
	task automatic t_reset;
		apb(1'b0, `CTU_CTRL_OFF, 32'h0);
		chk("control reset", `CTU_CTRL_RST, rd);
		apb(1'b0, `CTU_STAT_OFF, 32'h0);
		chk("status reset", 32'h0, rd);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		chk("unmapped err", 32'h1, err);
		chk("no self discharge", 32'h0, dis);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sources;
		for (int c = 0; c < 16; c++) begin
			sel <= 4'(c);
			apb(1'b1, `CTU_CTRL_OFF, 32'hC0000000 | (32'(c) << 26) | EN);
			lvl <= 1'b1;
			wait_flag(1'b0, s);
			chk("edge one source", 32'h1, s);
			lvl <= 1'b0;
			apb(1'b1, `CTU_CLR_OFF, 32'h3);
		end
		$display("source test done");
	endtask : t_sources
	task automatic t_pol_mode;
		sel <= 4'h0;
		apb(1'b1, `CTU_CTRL_OFF, 32'h80000000 | EN);
		lvl <= 1'b1;
		wait_flag(1'b0, s);
		chk("rise ignored", 32'h0, s);
		lvl <= 1'b0;
		wait_flag(1'b0, s);
		chk("fall seen", 32'h1, s);
		lvl <= 1'b1;
		apb(1'b1, `CTU_CTRL_OFF, 32'h40000000 | EN);
		wait_flag(1'b0, s);
		chk("level seen", 32'h1, s);
		// last level hit beats the clearing write, so write once more
		apb(1'b1, `CTU_CTRL_OFF, 32'hC0000000 | EN);
		apb(1'b1, `CTU_CTRL_OFF, 32'hC0000000 | EN);
		wait_flag(1'b0, s);
		chk("steady no edge", 32'h0, s);
		lvl <= 1'b0;
		$display("polarity test done");
	endtask : t_pol_mode
	task automatic t_edge2;
		sel <= 4'hE;
		apb(1'b1, `CTU_CTRL_OFF, 32'hC0F80000 | EN | 32'h1000);
		apb(1'b1, `CTU_CLR_OFF, 32'h3);
		apb(1'b1, `CTU_IEN_OFF, 32'h2);
		lvl <= 1'b1;
		wait_flag(1'b1, s);
		chk("edge two seen", 32'h1, s);
		apb(1'b0, `CTU_STAT_OFF, 32'h0);
		chk("status edge two", 32'h2, rd);
		chk("irq on", 32'h1, irq);
		apb(1'b1, `CTU_IEN_OFF, 32'h0);
		@(posedge core_clk_i);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, `CTU_IEN_OFF, 32'h2);
		apb(1'b1, `CTU_CLR_OFF, 32'h2);
		@(posedge core_clk_i);
		chk("irq cleared", 32'h0, irq);
		apb(1'b1, `CTU_CTRL_OFF, 32'h02000000);
		apb(1'b0, `CTU_CTRL_OFF, 32'h0);
		chk("flag writable", 32'h02000000, rd & 32'h02000000);
		lvl <= 1'b0;
		$display("edge two test done");
	endtask : t_edge2
	task automatic t_discharge;
		// discharge output trails the control bit by one register stage
		apb(1'b1, `CTU_CTRL_OFF, 32'h200);
		repeat (2) @(posedge core_clk_i);
		chk("discharge on", 32'h1, dis);
		apb(1'b1, `CTU_CTRL_OFF, 32'h0);
		repeat (2) @(posedge core_clk_i);
		chk("discharge off", 32'h0, dis);
		$display("discharge test done");
	endtask : t_discharge
	initial begin
		repeat (20) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_sources();
		t_pol_mode();
		t_edge2();
		t_discharge();
		stop_test();
	end
endmodule : charge_time_edge_control_tb_top
